// [design/emu_map_pkg.sv]
// Shared constants, types and decode helpers of the emulation map guard
package emu_map_pkg;
  localparam int ADDR_W   = 24;
  localparam int BLK_LSB  = 6;
  localparam int BLK_W    = ADDR_W - BLK_LSB;
  localparam int NUM_ENT  = 8;
  localparam int ENT_IW   = 3;
  localparam int NUM_EMU  = 4;
  localparam int EMU_IW   = 2;
  localparam int BASE_W   = 6;
  localparam int BIG_DROP = 2;
  localparam int SET_W    = 4;
  localparam int DATA_W   = 32;
  localparam int RADDR_W  = 8;
  localparam int CTRL_W   = 5;
  localparam int STAT_W   = 3;
  localparam int EB_GAP   = 2;

  // Register byte offsets
  localparam logic [RADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [RADDR_W-1:0] REG_STAT   = 8'h04;
  localparam logic [RADDR_W-1:0] REG_MASK   = 8'h08;
  localparam logic [RADDR_W-1:0] REG_ESEL   = 8'h0C;
  localparam logic [RADDR_W-1:0] REG_ESTART = 8'h10;
  localparam logic [RADDR_W-1:0] REG_EEND   = 8'h14;
  localparam logic [RADDR_W-1:0] REG_ESET   = 8'h18;
  localparam logic [RADDR_W-1:0] REG_ERRADR = 8'h1C;
  localparam logic [RADDR_W-1:0] REG_INFO   = 8'h20;
  localparam logic [3:0]         EBASE_PAGE = 4'h3;

  // Control, status and field bit positions
  localparam int C_BRK    = 0;
  localparam int C_RT     = 1;
  localparam int C_ROMWR  = 2;
  localparam int C_USIG   = 3;
  localparam int C_SCHIP  = 4;
  localparam int C_MRST   = 5;
  localparam int S_ERR    = 0;
  localparam int S_BRK    = 1;
  localparam int S_REF    = 2;
  localparam int ESET_VLD = 4;
  localparam int EB_EN    = 8;

  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
  localparam logic [1:0]        BIG_PAD  = 2'h0;

  // Fixed on-chip regions, as 64-byte block numbers
  localparam logic [BLK_W-1:0] ROM_LO = 18'h00000;
  localparam logic [BLK_W-1:0] ROM_HI = 18'h00FFF;
  localparam logic [BLK_W-1:0] RAM_LO = 18'h3FEC0;
  localparam logic [BLK_W-1:0] RAM_HI = 18'h3FFBE;
  localparam logic [BLK_W-1:0] IO_LO  = 18'h3FFE0;
  localparam logic [BLK_W-1:0] IO_HI  = 18'h3FFFF;

  localparam logic [1:0] ATTR_GUARD = 2'h0;
  localparam logic [1:0] ATTR_RO    = 2'h1;
  localparam logic [1:0] ATTR_RW    = 2'h2;

  typedef enum logic [1:0] {
    DEST_CHIP = 2'b00,
    DEST_USER = 2'b01,
    DEST_EMU  = 2'b10,
    DEST_NONE = 2'b11
  } dest_t;

  function automatic dest_t set_dest(input logic [SET_W-1:0] s);
    return dest_t'(s[3:2]);
  endfunction

  function automatic logic [1:0] set_attr(input logic [SET_W-1:0] s);
    return s[1:0];
  endfunction

  function automatic logic in_rng(input logic [BLK_W-1:0] v,
                                  input logic [BLK_W-1:0] lo,
                                  input logic [BLK_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Large modules compare fewer top bits, so the base must be aligned
  function automatic logic emu_match(input logic [BLK_W-1:0]  b,
                                     input logic [BASE_W-1:0] base,
                                     input logic              big);
    if (big)
      return b[BLK_W-1 -: BASE_W-BIG_DROP] ==
             base[BASE_W-1 -: BASE_W-BIG_DROP];
    return b[BLK_W-1 -: BASE_W] == base;
  endfunction
endpackage

// [design/lookup_if.sv]
// Map table contents and lookup results between guard and lookup unit
`timescale 1ns/10ps
interface lookup_if import emu_map_pkg::*; ();
  logic [BLK_W-1:0]  blk;
  logic [BLK_W-1:0]  ent_lo  [NUM_ENT];
  logic [BLK_W-1:0]  ent_hi  [NUM_ENT];
  logic [SET_W-1:0]  ent_set [NUM_ENT];
  logic [NUM_ENT-1:0] ent_vld;
  logic [BASE_W-1:0] base    [NUM_EMU];
  logic [NUM_EMU-1:0] emu_en;
  logic              big;
  dest_t             dest;
  logic [1:0]        attr;
  logic              chip_rom;
  logic              emu_hit;
  logic [EMU_IW-1:0] emu_idx;

  modport guard (output blk, ent_lo, ent_hi, ent_set, ent_vld, base,
                 emu_en, big, input dest, attr, chip_rom, emu_hit,
                 emu_idx);
  modport lookup (input blk, ent_lo, ent_hi, ent_set, ent_vld, base,
                  emu_en, big, output dest, attr, chip_rom, emu_hit,
                  emu_idx);
endinterface

// [design/map_lookup.sv]
// Combinational attribute and emulation block lookup for one access
`timescale 1ns/10ps
module map_lookup import emu_map_pkg::*; (
  lookup_if.lookup lk
);
  logic in_rom;
  logic in_ram;
  logic in_io;

  assign in_rom      = in_rng(lk.blk, ROM_LO, ROM_HI);
  assign in_ram      = in_rng(lk.blk, RAM_LO, RAM_HI);
  assign in_io       = in_rng(lk.blk, IO_LO, IO_HI);
  assign lk.chip_rom = in_rom;

  // R15: block index lookup
  always_comb begin
    lk.dest = DEST_USER;
    lk.attr = ATTR_GUARD;
    // R14: inclusive bounds, lowest entry wins
    for (int i = NUM_ENT - 1; i >= 0; i--) begin
      if (lk.ent_vld[i] && in_rng(lk.blk, lk.ent_lo[i], lk.ent_hi[i])) begin
        lk.dest = set_dest(lk.ent_set[i]);
        lk.attr = set_attr(lk.ent_set[i]);
      end
    end
    // R8: on-chip fixed attrs
    if (in_ram || in_io) begin
      lk.dest = DEST_CHIP;
      lk.attr = ATTR_RW;
    end
    if (in_rom) begin
      lk.dest = DEST_CHIP;
      lk.attr = ATTR_RO;
    end
  end

  // R4: four emulation blocks
  always_comb begin
    lk.emu_hit = 1'h0;
    lk.emu_idx = '0;
    for (int j = NUM_EMU - 1; j >= 0; j--) begin
      if (lk.emu_en[j] && emu_match(lk.blk, lk.base[j], lk.big)) begin
        lk.emu_hit = 1'h1;
        lk.emu_idx = EMU_IW'(j);
      end
    end
  end
endmodule // map_lookup

// [design/emu_map_guard.sv]
// Emulation memory map, access guard and configuration registers
`timescale 1ns/10ps
// How it works
// R1: Map resolution is one aligned 64-byte block.
// R2: Each block routes to emulation memory or user-system memory.
// R3: Each block is guarded, read-only or read-write.
// R4: Four placeable emulation memory blocks exist.
// R5: Emulation block size is 256 kbyte or 1 Mbyte, set by module.
// R6: Emulation block bases align to their own size boundary.
// R7: With break enabled, guarded access or protected write halts program.
// R8: On-chip region attributes are fixed; only user and emulator editable.
// R9: Single-chip mode refuses user read-write or read-only entries.
// R10: Map reset returns every entry to the default map.
// R11: Run-time access lets host reach memory while program runs.
// R12: Internal ROM writes happen only when ROM write is enabled.
// R13: User reset, NMI, standby, bus request pass only when enabled.
// R14: Host gives inclusive start and end block plus a setting.
// R15: Lookup uses address bits above bit 5, one clock later.
module emu_map_guard import emu_map_pkg::*; (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               ce,
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata_r,
  input  wire logic               mod_1mb,
  input  wire logic               acc_valid,
  input  wire logic [ADDR_W-1:0]  acc_addr,
  input  wire logic               acc_write,
  input  wire logic               cpu_run,
  input  wire logic               host_req,
  input  wire logic               usr_reset_in,
  input  wire logic               usr_nmi_in,
  input  wire logic               usr_stby_in,
  input  wire logic               usr_breq_in,
  output logic                    acc_done_r,
  output logic                    acc_ok_r,
  output logic      [1:0]         acc_dest_r,
  output logic                    acc_emu_r,
  output logic      [EMU_IW-1:0]  acc_emu_idx_r,
  output logic                    brk_r,
  output logic                    host_gnt_r,
  output logic                    usr_reset_r,
  output logic                    usr_nmi_r,
  output logic                    usr_stby_r,
  output logic                    usr_breq_r,
  output logic                    irq_r
);
  logic [CTRL_W-1:0]  ctrl_r;
  logic [STAT_W-1:0]  stat_r;
  logic [STAT_W-1:0]  mask_r;
  logic [ENT_IW-1:0]  esel_r;
  logic [BLK_W-1:0]   stg_lo_r;
  logic [BLK_W-1:0]   stg_hi_r;
  logic [BLK_W-1:0]   ent_lo_r  [NUM_ENT];
  logic [BLK_W-1:0]   ent_hi_r  [NUM_ENT];
  logic [SET_W-1:0]   ent_set_r [NUM_ENT];
  logic [NUM_ENT-1:0] ent_vld_r;
  logic [BASE_W-1:0]  base_r    [NUM_EMU];
  logic [NUM_EMU-1:0] emu_en_r;
  logic [ADDR_W-1:0]  err_addr_r;
  logic [DATA_W-1:0]  rd_val;
  logic [STAT_W-1:0]  stat_nxt;
  logic [STAT_W-1:0]  mask_nxt;
  logic [STAT_W-1:0]  ev;
  logic [STAT_W-1:0]  clr;

  lookup_if lk ();

  map_lookup u_lookup (
    .lk (lk)
  );

  // Register decode
  wire              wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  wire              wr_stat  = reg_wr && (reg_addr == REG_STAT);
  wire              wr_mask  = reg_wr && (reg_addr == REG_MASK);
  wire              wr_esel  = reg_wr && (reg_addr == REG_ESEL);
  wire              wr_lo    = reg_wr && (reg_addr == REG_ESTART);
  wire              wr_hi    = reg_wr && (reg_addr == REG_EEND);
  wire              wr_eset  = reg_wr && (reg_addr == REG_ESET);
  wire              is_ebase = reg_addr[RADDR_W-1:4] == EBASE_PAGE;
  wire              wr_ebase = reg_wr && is_ebase;
  wire [EMU_IW-1:0] eb_idx   = reg_addr[3:2];
  // R10: map reset command
  wire              map_clr  = wr_ctrl && reg_wdata[C_MRST];

  // Entry commit checks
  wire [SET_W-1:0]  w_set    = reg_wdata[SET_W-1:0];
  wire dest_t       w_dest   = set_dest(w_set);
  wire [1:0]        w_attr   = set_attr(w_set);
  wire              w_vld    = reg_wdata[ESET_VLD];
  // R8: on-chip setting refused
  wire              ref_chip = (w_dest == DEST_CHIP);
  // R9: single-chip user refusal
  wire              ref_sc   = ctrl_r[C_SCHIP] && (w_dest == DEST_USER) &&
                               (w_attr != ATTR_GUARD);
  wire              ref_bad  = (w_dest == DEST_NONE) ||
                               (w_attr != ATTR_GUARD && w_attr != ATTR_RO &&
                                w_attr != ATTR_RW);
  // R14: start must not pass end
  wire              ref_rng  = stg_lo_r > stg_hi_r;
  wire              refuse   = wr_eset && w_vld &&
                               (ref_chip || ref_sc || ref_bad || ref_rng);
  wire              ent_we   = wr_eset && !refuse;

  // R6: 1-Mbyte bases drop the low base bits
  wire [BASE_W-1:0] base_nxt = mod_1mb ?
                               {reg_wdata[BASE_W-1:BIG_DROP], BIG_PAD} :
                               reg_wdata[BASE_W-1:0];

  // R1: block number from access
  assign lk.blk     = acc_addr[ADDR_W-1:BLK_LSB];
  assign lk.ent_lo  = ent_lo_r;
  assign lk.ent_hi  = ent_hi_r;
  assign lk.ent_set = ent_set_r;
  assign lk.ent_vld = ent_vld_r;
  assign lk.base    = base_r;
  assign lk.emu_en  = emu_en_r;
  // R5: module size from strap
  assign lk.big     = mod_1mb;

  // R3: guard and write protect
  wire rom_wr_ok = lk.chip_rom && ctrl_r[C_ROMWR];
  wire emu_miss  = (lk.dest == DEST_EMU) && !lk.emu_hit;
  wire wr_prot   = acc_write && (lk.attr == ATTR_RO) && !rom_wr_ok;
  wire viol      = acc_valid &&
                   ((lk.attr == ATTR_GUARD) || emu_miss || wr_prot);
  // R7: break on access error
  wire brk_nxt   = viol && ctrl_r[C_BRK];

  // Sticky events; a set in the clearing cycle survives
  assign ev       = {refuse, brk_nxt, viol};
  assign clr      = wr_stat ? reg_wdata[STAT_W-1:0] : STAT_RST;
  assign stat_nxt = (stat_r & ~clr) | ev;
  assign mask_nxt = wr_mask ? reg_wdata[STAT_W-1:0] : mask_r;

  always_comb begin
    rd_val = '0;
    case (reg_addr)
      REG_CTRL:   rd_val = DATA_W'(ctrl_r);
      REG_STAT:   rd_val = DATA_W'(stat_r);
      REG_MASK:   rd_val = DATA_W'(mask_r);
      REG_ESEL:   rd_val = DATA_W'(esel_r);
      REG_ESTART: rd_val = DATA_W'(ent_lo_r[esel_r]);
      REG_EEND:   rd_val = DATA_W'(ent_hi_r[esel_r]);
      REG_ESET:   rd_val = DATA_W'({ent_vld_r[esel_r], ent_set_r[esel_r]});
      REG_ERRADR: rd_val = DATA_W'(err_addr_r);
      REG_INFO:   rd_val = DATA_W'(mod_1mb);
      default: begin
        if (is_ebase)
          rd_val = DATA_W'({emu_en_r[eb_idx], {EB_GAP{1'h0}},
                            base_r[eb_idx]});
      end
    endcase
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r   <= CTRL_RST;
      mask_r   <= STAT_RST;
      esel_r   <= '0;
      stg_lo_r <= '0;
      stg_hi_r <= '0;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[CTRL_W-1:0];
      mask_r <= mask_nxt;
      if (wr_esel)
        esel_r <= reg_wdata[ENT_IW-1:0];
      if (wr_lo)
        stg_lo_r <= reg_wdata[BLK_W-1:0];
      if (wr_hi)
        stg_hi_r <= reg_wdata[BLK_W-1:0];
    end
  end

  // R2: map entry table
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ent_vld_r <= '0;
      for (int i = 0; i < NUM_ENT; i++) begin
        ent_lo_r[i]  <= '0;
        ent_hi_r[i]  <= '0;
        ent_set_r[i] <= '0;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        // R10: clear to default map
        if (map_clr) begin
          ent_vld_r[i] <= 1'h0;
          ent_set_r[i] <= '0;
        end else if (ent_we && (esel_r == ENT_IW'(i))) begin
          ent_vld_r[i] <= w_vld;
          ent_lo_r[i]  <= stg_lo_r;
          ent_hi_r[i]  <= stg_hi_r;
          ent_set_r[i] <= w_set;
        end
      end
    end
  end

  // R4: emulation block bases
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      emu_en_r <= '0;
      for (int j = 0; j < NUM_EMU; j++)
        base_r[j] <= '0;
    end else if (ce) begin
      if (wr_ebase) begin
        base_r[eb_idx]   <= base_nxt;
        emu_en_r[eb_idx] <= reg_wdata[EB_EN];
      end
    end
  end

  // Status, interrupt and read port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r      <= STAT_RST;
      irq_r       <= 1'h0;
      reg_rdata_r <= '0;
      err_addr_r  <= '0;
    end else if (ce) begin
      stat_r      <= stat_nxt;
      irq_r       <= |(stat_nxt & mask_nxt);
      reg_rdata_r <= reg_rd ? rd_val : '0;
      if (viol)
        err_addr_r <= acc_addr;
    end
  end

  // R15: access result, one clock later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_done_r    <= 1'h0;
      acc_ok_r      <= 1'h0;
      acc_dest_r    <= DEST_USER;
      acc_emu_r     <= 1'h0;
      acc_emu_idx_r <= '0;
      brk_r         <= 1'h0;
    end else if (ce) begin
      acc_done_r    <= acc_valid;
      // R12: ROM write gate
      acc_ok_r      <= acc_valid && !viol;
      acc_dest_r    <= lk.dest;
      acc_emu_r     <= acc_valid && (lk.dest == DEST_EMU) && lk.emu_hit;
      acc_emu_idx_r <= lk.emu_idx;
      brk_r         <= brk_nxt;
    end
  end

  // R11: run-time host access
  // R13: user signal gating
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_gnt_r  <= 1'h0;
      usr_reset_r <= 1'h0;
      usr_nmi_r   <= 1'h0;
      usr_stby_r  <= 1'h0;
      usr_breq_r  <= 1'h0;
    end else if (ce) begin
      host_gnt_r  <= host_req && (!cpu_run || ctrl_r[C_RT]);
      usr_reset_r <= usr_reset_in && ctrl_r[C_USIG];
      usr_nmi_r   <= usr_nmi_in && ctrl_r[C_USIG];
      usr_stby_r  <= usr_stby_in && ctrl_r[C_USIG];
      usr_breq_r  <= usr_breq_in && ctrl_r[C_USIG];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_bad_acc;
    ce && viol;
  endsequence

  sequence s_commit;
    ce && wr_eset && w_vld;
  endsequence

  a_brk_on_err: assert property (s_bad_acc ##0 ctrl_r[C_BRK] |=> brk_r) // R7
    else $error("break missing after access error");
  a_brk_quiet: assert property (ce && !ctrl_r[C_BRK] |=> !brk_r) // R7
    else $error("break raised while disabled");
  a_guard_blk: assert property ( // R3
    ce && acc_valid && lk.attr == ATTR_GUARD |=> !acc_ok_r && stat_r[S_ERR])
    else $error("guarded access not flagged");
  a_rom_write: assert property ( // R12
    ce && acc_valid && acc_write && lk.chip_rom && !ctrl_r[C_ROMWR]
    |=> acc_done_r && !acc_ok_r)
    else $error("ROM write allowed while disabled");
  a_host_block: assert property ( // R11
    ce && host_req && cpu_run && !ctrl_r[C_RT] |=> !host_gnt_r)
    else $error("host granted during run without run-time access");
  a_usr_gate: assert property (ce && !ctrl_r[C_USIG] // R13
    |=> !(usr_reset_r || usr_nmi_r || usr_stby_r || usr_breq_r))
    else $error("user signal passed while disabled");
  a_map_clear: assert property (ce && map_clr |=> ent_vld_r == '0) // R10
    else $error("map not cleared by reset command");
  a_chip_fixed: assert property ( // R8
    s_commit ##0 ref_chip |=> $stable(ent_vld_r) && stat_r[S_REF])
    else $error("on-chip setting accepted");
  a_single_chip: assert property ( // R9
    s_commit ##0 ref_sc |=> $stable(ent_vld_r) && stat_r[S_REF])
    else $error("user entry accepted in single-chip mode");
  a_acc_done: assert property (ce && acc_valid |=> acc_done_r ##1 1'h1) // R15
    else $error("access result missing");

  sequence s_emu_acc;
    ce && acc_valid && lk.emu_hit;
  endsequence

  // Base compare restated from raw address bits, apart from the lookup
  a_base_small: assert property ( // R5
    s_emu_acc ##0 !mod_1mb
    |-> base_r[lk.emu_idx] == acc_addr[ADDR_W-1 -: BASE_W])
    else $error("small emulation block hit outside its base");
  a_base_big: assert property ( // R5
    s_emu_acc ##0 mod_1mb |-> base_r[lk.emu_idx][BASE_W-1:BIG_DROP] ==
                              acc_addr[ADDR_W-1 -: BASE_W-BIG_DROP])
    else $error("large emulation block hit outside its base");
  a_base_align: assert property ( // R6
    ce && wr_ebase && mod_1mb
    |=> base_r[$past(eb_idx)][BIG_DROP-1:0] == BIG_PAD)
    else $error("large block base stored unaligned");
  a_emu_miss: assert property ( // R2
    ce && acc_valid && lk.dest == DEST_EMU && !lk.emu_hit
    |=> !acc_ok_r && !acc_emu_r && acc_dest_r == DEST_EMU)
    else $error("emulation access without matching block allowed");
  a_wr_protect: assert property ( // R3
    ce && acc_valid && acc_write && lk.attr == ATTR_RO && !lk.chip_rom
    |=> !acc_ok_r && stat_r[S_ERR])
    else $error("write to read-only block allowed");
  a_rom_wr_ok: assert property ( // R12
    ce && acc_valid && acc_write && lk.chip_rom && ctrl_r[C_ROMWR]
    |=> acc_ok_r)
    else $error("ROM write refused while enabled");
  a_err_addr: assert property ( // R7
    s_bad_acc |=> err_addr_r == $past(acc_addr))
    else $error("violating address not captured");
  a_range_ref: assert property ( // R14
    s_commit ##0 ref_rng |=> $stable(ent_vld_r) && stat_r[S_REF])
    else $error("entry with start past end accepted");
  a_sc_emu_ok: assert property ( // R9
    s_commit ##0 (ctrl_r[C_SCHIP] && w_dest == DEST_EMU && !ref_bad && !ref_rng)
    |=> ent_vld_r[$past(esel_r)])
    else $error("emulation entry refused in single-chip mode");
endmodule // emu_map_guard

// [dv/core_bus_model.sv]
// Core bus model that issues one access per request
`timescale 1ns/10ps
module core_bus_model import emu_map_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              req,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_wr,
  output logic                   acc_valid,
  output logic      [ADDR_W-1:0] acc_addr,
  output logic                   acc_write
);
  // Idle bus toggles, so a stale address is never mistaken for a live one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_valid <= 1'b0;
      acc_addr  <= 24'h000000;
      acc_write <= 1'b0;
    end else begin
      acc_valid <= req;
      acc_addr  <= req ? req_addr : ~acc_addr;
      acc_write <= req ? req_wr : ~acc_write;
    end
  end
endmodule // core_bus_model

// [dv/emu_map_guard_tb.sv]
// Self-checking bench of the emulation map guard
`timescale 1ns/10ps
module emu_map_guard_tb import emu_map_pkg::*; ;
  logic              clk, rst_b, ce, reg_wr, reg_rd, mod_1mb;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata_r;
  logic              req, req_wr, acc_valid, acc_write, cpu_run, host_req;
  logic [23:0]       req_addr, acc_addr, err;
  logic [3:0]        usr_in;
  logic              acc_done_r, acc_ok_r, acc_emu_r, brk_r, host_gnt_r;
  logic              usr_reset_r, usr_nmi_r, usr_stby_r, usr_breq_r, irq_r;
  logic [1:0]        acc_dest_r, acc_emu_idx_r;
  logic [4:0]        ctrl;
  logic [2:0]        stat, mask;
  logic [3:0]        st [8];
  logic              vld [8], ben [4];
  logic [5:0]        bas [4];
  int                lo [8], hi [8], n_fail, checks_done;
  logic [31:0]       r;

  emu_map_guard u_dut (.clk(clk), .rst_b(rst_b), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .mod_1mb(mod_1mb),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .cpu_run(cpu_run), .host_req(host_req), .usr_reset_in(usr_in[3]),
    .usr_nmi_in(usr_in[2]), .usr_stby_in(usr_in[1]),
    .usr_breq_in(usr_in[0]), .acc_done_r(acc_done_r), .acc_ok_r(acc_ok_r),
    .acc_dest_r(acc_dest_r), .acc_emu_r(acc_emu_r),
    .acc_emu_idx_r(acc_emu_idx_r), .brk_r(brk_r), .host_gnt_r(host_gnt_r),
    .usr_reset_r(usr_reset_r), .usr_nmi_r(usr_nmi_r),
    .usr_stby_r(usr_stby_r), .usr_breq_r(usr_breq_r), .irq_r(irq_r));

  core_bus_model u_core (.clk(clk), .rst_b(rst_b), .req(req),
    .req_addr(req_addr), .req_wr(req_wr), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_write(acc_write));

  always #25 clk = ~clk;

  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Model tracks control, status, mask and emulation base side effects as the write lands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == REG_CTRL) begin
      ctrl = d[4:0];
      if (d[C_MRST])
        foreach (vld[i]) begin
          vld[i] = 1'b0;
          st[i] = 4'h0;
        end
    end
    if (a == REG_STAT) stat = stat & ~d[2:0];
    if (a == REG_MASK) mask = d[2:0];
    if (a >= 8'h30 && a <= 8'h3C) begin
      bas[(a - 8'h30) >> 2] = mod_1mb ? {d[5:2], 2'h0} : d[5:0];
      ben[(a - 8'h30) >> 2] = d[EB_EN];
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_r, e);
  endtask

  function automatic logic [6:0] pred(input logic [23:0] a, input logic w);
    int b;
    logic [1:0] d, at, ix;
    logic hit, e, ok;
    b = a >> 6;
    d = 2'h1;
    at = ATTR_GUARD;
    hit = 1'b0;
    e = 1'b0;
    ix = 2'h0;
    if (a <= 24'h03FFFF) begin
      d = 2'h0;
      at = ctrl[C_ROMWR] ? ATTR_RW : ATTR_RO;
    end else if ((a >= 24'hFFB000 && a <= 24'hFFEFBF) || a >= 24'hFFF800) begin
      d = 2'h0;
      at = ATTR_RW;
    end else
      for (int i = 0; i < 8; i++)
        if (!hit && vld[i] && b >= lo[i] && b <= hi[i]) begin
          hit = 1'b1;
          d = st[i][3:2];
          at = st[i][1:0];
        end
    if (d == 2'h2)
      for (int k = 3; k >= 0; k--)
        if (ben[k] && (mod_1mb ? a[23:20] == bas[k][5:2]
                               : a[23:18] == bas[k])) begin
          e = 1'b1;
          ix = 2'(k);
        end
    ok = at != ATTR_GUARD && !(w && at == ATTR_RO) && !(d == 2'h2 && !e);
    return {!ok && ctrl[C_BRK], ok, d, e, ix};
  endfunction

  task automatic acc(input logic [23:0] a, input logic w);
    logic [6:0] p;
    p = pred(a, w);
    @(posedge clk);
    req <= 1'b1;
    req_addr <= a;
    req_wr <= w;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    if (!p[5]) begin
      stat[S_ERR] = 1'b1;
      stat[S_BRK] = stat[S_BRK] | p[6];
      err = a;
    end
    #1 chk({brk_r, acc_ok_r, acc_dest_r, acc_emu_r}, p[6:2]);
    chk(acc_done_r, 1'b1);
    if (p[2]) chk(acc_emu_idx_r, p[1:0]);
    chk(irq_r, |(stat & mask));
  endtask

  // Host hands over inclusive start and end blocks with the setting
  // host entry definition
  task automatic ent(input int i, input int l, input int h,
                     input logic [3:0] s);
    logic bad;
    bad = s[3:2] == 2'h0 || s[3:2] == 2'h3 || s[1:0] == 2'h3 || l > h ||
          (ctrl[C_SCHIP] && s[3:2] == 2'h1 && s[1:0] != ATTR_GUARD);
    wr(REG_ESEL, i);
    wr(REG_ESTART, l);
    wr(REG_EEND, h);
    wr(REG_ESET, {27'h0, 1'b1, s});
    if (bad)
      stat[S_REF] = 1'b1;
    else begin
      lo[i] = l;
      hi[i] = h;
      st[i] = s;
      vld[i] = 1'b1;
    end
    rdc(REG_ESET, {vld[i], st[i]});
    chk(irq_r, |(stat & mask));
  endtask

  initial begin
    #(50 * 40000);
    n_fail++;
    complete_run();
  end

  initial begin
    {clk, ce, reg_wr, reg_rd, mod_1mb, req, req_wr, cpu_run, host_req} = 0;
    {reg_addr, reg_wdata, req_addr, usr_in, err, ctrl, stat, mask} = 0;
    foreach (vld[i]) {vld[i], st[i]} = 0;
    foreach (ben[k]) {ben[k], bas[k]} = 0;
    n_fail = 0;
    checks_done = 0;
    rst_b = 1'b0;
    void'($urandom(32'h2F5E));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    ce <= 1'b1;
    chk({acc_done_r, acc_ok_r, brk_r, host_gnt_r, irq_r, acc_dest_r}, 32'h1);
    rdc(REG_CTRL, 32'h0);
    rdc(8'h40, 32'h0);
    wr(REG_MASK, 32'h7);
    acc(24'h000100, 1'b0);
    acc(24'h000100, 1'b1);
    wr(REG_CTRL, 32'h5);
    acc(24'h03FFC0, 1'b1);
    acc(24'hFFEFBF, 1'b1);
    acc(24'hFFEFC0, 1'b0);
    rdc(REG_STAT, {29'h0, stat});
    rdc(REG_ERRADR, {8'h0, err});
    wr(REG_STAT, 32'h3);
    rdc(REG_STAT, {29'h0, stat});
    ent(0, 32'h100000 >> 6, 32'h10FFC0 >> 6, {DEST_USER, ATTR_RW});
    ent(1, 32'h200000 >> 6, 32'h200000 >> 6, {DEST_USER, ATTR_RO});
    acc(24'h10FFFF, 1'b1);
    acc(24'h110000, 1'b1);
    acc(24'h200000, 1'b0);
    acc(24'h200000, 1'b1);
    acc(24'h200040, 1'b0);
    ent(2, 32'h300000 >> 6, 32'h33FFC0 >> 6, {DEST_EMU, ATTR_RW});
    acc(24'h300000, 1'b0);
    wr(8'h30, 32'h10C);
    acc(24'h33FFFF, 1'b1);
    acc(24'h340000, 1'b1);
    mod_1mb <= 1'b1;
    ent(3, 32'h800000 >> 6, 32'h8FFFC0 >> 6, {DEST_EMU, ATTR_RO});
    wr(8'h3C, 32'h123);
    rdc(8'h3C, 32'h120);
    rdc(REG_INFO, 32'h1);
    acc(24'h8FFFC0, 1'b0);
    acc(24'h8FFFC0, 1'b1);
    ent(4, 32'h5, 32'h4, {DEST_USER, ATTR_RW});
    wr(REG_CTRL, 32'h15);
    ent(4, 32'hA000, 32'hA0FF, {DEST_USER, ATTR_RW});
    ent(4, 32'hA000, 32'hA0FF, {DEST_USER, ATTR_RO});
    ent(4, 32'hA000, 32'hA0FF, {DEST_USER, ATTR_GUARD});
    ent(5, 32'hA000, 32'hA0FF, {DEST_CHIP, ATTR_RW});
    ent(6, 32'hA000, 32'hA0FF, {DEST_EMU, ATTR_RW});
    repeat (60) begin
      r = $urandom;
      acc(r[23:0], r[31]);
    end
    wr(REG_CTRL, 32'h25);
    rdc(REG_CTRL, 32'h5);
    rdc(REG_ESET, 32'h0);
    acc(24'h100000, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(REG_CTRL, i[2] ? 32'hA : 32'h0);
      r = $urandom;
      @(posedge clk);
      cpu_run <= i[0];
      host_req <= i[1];
      usr_in <= r[3:0];
      @(posedge clk);
      #1 chk({usr_reset_r, usr_nmi_r, usr_stby_r, usr_breq_r},
          r[3:0] & {4{i[2]}});
      chk(host_gnt_r, i[1] & (!i[0] | i[2]));
    end
    complete_run();
  end
endmodule // emu_map_guard_tb
